// ==== lsd_pkg.sv ====
// Shared constants and state types for the LIN slave header and divider block
package lsd_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL2  = 8'h04;
  localparam logic [7:0] OFS_CTRL3  = 8'h08;
  localparam logic [7:0] OFS_BAUD   = 8'h0c;
  localparam logic [7:0] OFS_ETPR   = 8'h10;
  localparam logic [7:0] OFS_ERPR   = 8'h14;

  // Control register three bit positions
  localparam int C3_UPD = 7;
  localparam int C3_EN  = 6;
  localparam int C3_SLV = 5;
  localparam int C3_ASE = 4;
  localparam int C3_HDM = 3;
  localparam int C3_HIE = 2;
  localparam int C3_HDF = 1;
  localparam int C3_SF  = 0;

  // Control register two bit positions
  localparam int C2_MUTE = 1;
  localparam int C2_SBK  = 0;

  // Status register bit positions
  localparam int ST_TXIDLE = 7;
  localparam int ST_HDF    = 1;
  localparam int ST_SF     = 0;

  // Values after reset and loaded on header events
  localparam logic [7:0]  RST_REG     = 8'h00;
  localparam logic [11:0] RST_LIN_DIVIDER    = 12'h000;
  localparam logic [7:0]  LHL_BREAK   = 8'hff;
  localparam logic [7:0]  LHL_TIMEOUT = 8'h00;

  // Bit counts; the line is tracked in quarter bit times
  localparam int Q_PER_BIT          = 4;
  localparam int TX_BRK_BITS_MASTER = 13;
  localparam int TX_WORD_BITS       = 10;
  localparam int RX_BRK_BITS        = 11;
  localparam int HDR_MAX_BITS       = 57;
  localparam int ID_CHAR_BITS       = 10;
  localparam int SYNCH_FALLS        = 5;
  localparam int SYNCH_SHIFT        = 3;

  typedef enum logic [1:0] {LSD_TX_IDLE, LSD_TX_BREAK, LSD_TX_STOP} lsd_tx_t;
  typedef enum logic [2:0] {LSD_RX_IDLE, LSD_RX_LOW, LSD_RX_WAIT_HIGH, LSD_RX_SYNCH,
                            LSD_RX_ID_WAIT, LSD_RX_ID} lsd_rx_t;

endpackage

// ==== lsd_qtick_gen.sv ====
// Quarter bit time tick generator driven by the effective divider
`timescale 1ns/1ps
module lsd_qtick_gen (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic [9:0] period,
  output logic            qtick
);

  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } lsd_qg_t;

  lsd_qg_t s_ff;
  lsd_qg_t nxt_s;

  // Counter wraps at period; disabled counter stays parked at zero
  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (!en)
    begin
      nxt_s.cnt = 10'h000;
    end
    else if (s_ff.cnt >= period - 10'h001)
    begin
      nxt_s.cnt  = 10'h000;
      nxt_s.tick = 1'b1;
    end
    else
    begin
      nxt_s.cnt = s_ff.cnt + 10'h001;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign qtick = s_ff.tick; // Registered pulse

endmodule

// ==== lsd_core.sv ====
// LIN break, header detection, divider and header length logic with APB registers
`timescale 1ns/1ps

// Overview of operation
// - Send-break bit high keeps sending breaks
// - Set then clear sends one break
// - Update method 0: mantissa write loads divider
// - Update method 1: load on next character
// - Enable and slave bits select the mode
// - Master break lasts thirteen low bits
// - Slave detects break after eleven low bits
// - Slave mode blocks break transmission
// - Slave maps divider onto baud prescaler addresses
// - Mute wake condition chosen by detect method
// - Method 1 needs break, synch, identifier
// - Header flag cleared by status then read
// - Header interrupt when enabled and flag set
// - Auto synch works only in slave mode
// - Synch state bit set, cleared, software exit
// - Synch state counts falling edges on input
// - Mantissa gives divider integer part directly
// - Fraction low nibble, upper bits read zero
// - Fraction first; mantissa write applies divider
// - Mantissa zero stops the serial clocks
// - Header length visible only when enabled
// - Length loads FFh, 00h, or encoded value
// - Encoded length is 57 minus header time
module lsd_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   irq
);

  typedef struct packed {
    logic [7:0]      ctrl2;
    logic [7:0]      ctrl3;
    logic [7:0]      baud;
    logic [7:0]      etpr;
    logic [7:0]      erpr;
    logic [7:0]      mant;
    logic [3:0]      frac;
    logic [7:0]      encoded_header_length;
    logic [11:0]     lin_divider;
    logic            brk_pend;
    logic            stat_seen;
    logic            rx_meta;
    logic            rx_sync;
    logic            rx_prev;
    lsd_pkg::lsd_tx_t tx_st;
    logic [5:0]      tx_q;
    lsd_pkg::lsd_rx_t rx_st;
    logic [7:0]      rx_q;
    logic [7:0]      hdr_q;
    logic [2:0]      falls;
    logic [19:0]     syn_cnt;
    logic            txd;
    logic [31:0]     prdata;
  } lsd_state_t;

  lsd_state_t s_ff;
  lsd_state_t nxt_s;

  logic       lin_on;
  logic       slave;
  logic       master;
  logic       qtick;
  logic       gen_en;
  logic [9:0] gen_period;
  logic [7:0] addr;
  logic       mapped;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] rd_val;
  logic       fall;
  logic       lhl_vis;

  // Encoded header length from elapsed quarter bits, fraction in the low two bits
  function automatic logic [7:0] lsd_enc_len(input logic [7:0] q);
    lsd_enc_len = 8'(lsd_pkg::HDR_MAX_BITS * lsd_pkg::Q_PER_BIT) - q;
  endfunction

  // Auto synch result: eight bit times measured, divided down to 1/16 units
  function automatic logic [11:0] lsd_sync_div(input logic [19:0] cnt);
    if (|cnt[19:15])
      lsd_sync_div = 12'hfff;
    else
      lsd_sync_div = cnt[14:3];
  endfunction

  // Mode decode
  assign lin_on = s_ff.ctrl3[lsd_pkg::C3_EN];
  assign slave  = lin_on & s_ff.ctrl3[lsd_pkg::C3_SLV];
  assign master = lin_on & ~s_ff.ctrl3[lsd_pkg::C3_SLV];

  // Clock source: divider in slave mode, plain prescaler otherwise
  assign gen_en     = slave ? (s_ff.lin_divider[11:4] != 8'h00) : (s_ff.baud != 8'h00);
  assign gen_period = slave ? s_ff.lin_divider[11:2] : {s_ff.baud, 2'b00};

  lsd_qtick_gen u_qtick (
    .clk    (clk),
    .rst    (rst),
    .en     (gen_en),
    .period (gen_period),
    .qtick  (qtick)
  );

  // APB decode; zero wait states, unmapped or misaligned offsets answer an error
  assign addr    = 8'(paddr);
  assign mapped  = (ADDR_W <= 8 || (paddr >> 8) == '0) &&
                   (addr == lsd_pkg::OFS_STATUS || addr == lsd_pkg::OFS_CTRL2 ||
                    addr == lsd_pkg::OFS_CTRL3  || addr == lsd_pkg::OFS_BAUD  ||
                    addr == lsd_pkg::OFS_ETPR   || addr == lsd_pkg::OFS_ERPR);
  assign acc     = psel & penable & mapped;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign fall    = s_ff.rx_prev & ~s_ff.rx_sync;
  assign lhl_vis = slave & (s_ff.ctrl3[lsd_pkg::C3_ASE] | s_ff.ctrl3[lsd_pkg::C3_HDM]);

  // Read mux, sampled in the setup phase so prdata comes from a flip-flop
  always_comb
  begin
    rd_val = 8'h00;
    case (addr)
      lsd_pkg::OFS_STATUS:
      begin
        rd_val[lsd_pkg::ST_TXIDLE] = (s_ff.tx_st == lsd_pkg::LSD_TX_IDLE);
        rd_val[lsd_pkg::ST_HDF]    = s_ff.ctrl3[lsd_pkg::C3_HDF];
        rd_val[lsd_pkg::ST_SF]     = s_ff.ctrl3[lsd_pkg::C3_SF];
      end
      lsd_pkg::OFS_CTRL2: rd_val = s_ff.ctrl2;
      lsd_pkg::OFS_CTRL3: rd_val = s_ff.ctrl3;
      // Slave reads show the divider in use, not the last value written
      lsd_pkg::OFS_BAUD:  rd_val = slave ? s_ff.lin_divider[11:4] : s_ff.baud;
      lsd_pkg::OFS_ETPR:  rd_val = slave ? {4'h0, s_ff.lin_divider[3:0]} : s_ff.etpr;
      lsd_pkg::OFS_ERPR:  rd_val = slave ? (lhl_vis ? s_ff.encoded_header_length : 8'h00) : s_ff.erpr;
      default:            rd_val = 8'h00;
    endcase
  end

  // Next state
  always_comb
  begin
    nxt_s = s_ff;

    // Receive input synchroniser and edge history
    nxt_s.rx_meta = rxd;
    nxt_s.rx_sync = s_ff.rx_meta;
    nxt_s.rx_prev = s_ff.rx_sync;

    if (psel && !penable && !pwrite)
      nxt_s.prdata = {24'h000000, rd_val};

    // Status access arms the header flag clear; any other mapped access disarms it
    if (acc)
      nxt_s.stat_seen = (addr == lsd_pkg::OFS_STATUS);
    if (rd && addr == lsd_pkg::OFS_CTRL3 && s_ff.stat_seen)
      nxt_s.ctrl3[lsd_pkg::C3_HDF] = 1'b0;

    // Register writes
    if (wr)
    begin
      case (addr)
        lsd_pkg::OFS_CTRL2:
        begin
          nxt_s.ctrl2 = pwdata[7:0];
          if (pwdata[lsd_pkg::C2_SBK])
            nxt_s.brk_pend = 1'b1;
        end
        lsd_pkg::OFS_CTRL3:
        begin
          // Flag is hardware owned; writing zero to the synch bit clears it and leaves synch state
          nxt_s.ctrl3[7:2] = pwdata[7:2];
          if (!pwdata[lsd_pkg::C3_SF])
          begin
            nxt_s.ctrl3[lsd_pkg::C3_SF] = 1'b0;
            if (s_ff.rx_st == lsd_pkg::LSD_RX_SYNCH)
              nxt_s.rx_st = lsd_pkg::LSD_RX_IDLE;
          end
        end
        lsd_pkg::OFS_BAUD:
        begin
          if (slave)
          begin
            nxt_s.mant = pwdata[7:0];
            // Fraction written earlier joins the mantissa here
            if (!s_ff.ctrl3[lsd_pkg::C3_UPD])
              nxt_s.lin_divider = {pwdata[7:0], s_ff.frac};
          end
          else
            nxt_s.baud = pwdata[7:0];
        end
        lsd_pkg::OFS_ETPR:
        begin
          if (slave)
            nxt_s.frac = pwdata[3:0];
          else
            nxt_s.etpr = pwdata[7:0];
        end
        lsd_pkg::OFS_ERPR:
        begin
          if (!slave)
            nxt_s.erpr = pwdata[7:0];
        end
        default:
        begin
        end
      endcase
    end

    // Break transmitter; slave mode aborts and blocks it
    case (s_ff.tx_st)
      lsd_pkg::LSD_TX_IDLE:
      begin
        nxt_s.txd = 1'b1;
        // Start on a quarter tick so the low time is whole bit times
        if (!slave && qtick && (s_ff.ctrl2[lsd_pkg::C2_SBK] || s_ff.brk_pend))
        begin
          nxt_s.tx_st    = lsd_pkg::LSD_TX_BREAK;
          nxt_s.tx_q     = 6'h00;
          nxt_s.brk_pend = wr && addr == lsd_pkg::OFS_CTRL2 && pwdata[lsd_pkg::C2_SBK];
          nxt_s.txd      = 1'b0;
        end
      end
      lsd_pkg::LSD_TX_BREAK:
      begin
        nxt_s.txd = 1'b0;
        if (slave)
        begin
          nxt_s.tx_st = lsd_pkg::LSD_TX_IDLE;
          nxt_s.txd   = 1'b1;
        end
        else if (qtick)
        begin
          nxt_s.tx_q = s_ff.tx_q + 6'h01;
          // Master mode stretches the break to a full LIN synch break
          if ((master && s_ff.tx_q == 6'(lsd_pkg::TX_BRK_BITS_MASTER * lsd_pkg::Q_PER_BIT - 1)) ||
              (!master && s_ff.tx_q == 6'(lsd_pkg::TX_WORD_BITS * lsd_pkg::Q_PER_BIT - 1)))
          begin
            nxt_s.tx_st = lsd_pkg::LSD_TX_STOP;
            nxt_s.tx_q  = 6'h00;
            nxt_s.txd   = 1'b1;
          end
        end
      end
      lsd_pkg::LSD_TX_STOP:
      begin
        nxt_s.txd = 1'b1;
        if (qtick)
        begin
          nxt_s.tx_q = s_ff.tx_q + 6'h01;
          if (s_ff.tx_q == 6'(lsd_pkg::Q_PER_BIT - 1))
            nxt_s.tx_st = lsd_pkg::LSD_TX_IDLE;
        end
      end
      default:
      begin
        nxt_s.tx_st = lsd_pkg::LSD_TX_IDLE;
        nxt_s.txd   = 1'b1;
      end
    endcase

    // Header elapsed time in quarter bits, saturating
    if (s_ff.rx_st != lsd_pkg::LSD_RX_IDLE && qtick && s_ff.hdr_q != 8'hff)
      nxt_s.hdr_q = s_ff.hdr_q + 8'h01;

    // Header receiver, active in slave mode only
    case (s_ff.rx_st)
      lsd_pkg::LSD_RX_IDLE:
      begin
        if (slave && fall)
        begin
          nxt_s.rx_st = lsd_pkg::LSD_RX_LOW;
          nxt_s.rx_q  = 8'h00;
          nxt_s.hdr_q = 8'h00;
        end
      end
      lsd_pkg::LSD_RX_LOW:
      begin
        if (s_ff.rx_sync)
          nxt_s.rx_st = lsd_pkg::LSD_RX_IDLE;
        else if (qtick)
        begin
          nxt_s.rx_q = s_ff.rx_q + 8'h01;
          if (s_ff.rx_q == 8'(lsd_pkg::RX_BRK_BITS * lsd_pkg::Q_PER_BIT - 1))
          begin
            nxt_s.rx_st                 = lsd_pkg::LSD_RX_WAIT_HIGH;
            nxt_s.ctrl3[lsd_pkg::C3_SF] = 1'b1;
            nxt_s.encoded_header_length                   = lsd_pkg::LHL_BREAK;
            if (!s_ff.ctrl3[lsd_pkg::C3_HDM])
            begin
              nxt_s.ctrl3[lsd_pkg::C3_HDF] = 1'b1;
              nxt_s.ctrl2[lsd_pkg::C2_MUTE] = 1'b0;
            end
          end
        end
      end
      lsd_pkg::LSD_RX_WAIT_HIGH:
      begin
        if (s_ff.rx_sync)
        begin
          nxt_s.rx_st = lsd_pkg::LSD_RX_SYNCH;
          nxt_s.falls = 3'h0;
        end
      end
      lsd_pkg::LSD_RX_SYNCH:
      begin
        // Time is measured from the first to the last falling edge
        if (s_ff.falls != 3'h0)
          nxt_s.syn_cnt = s_ff.syn_cnt + 20'h00001;
        if (fall)
        begin
          nxt_s.falls = s_ff.falls + 3'h1;
          if (s_ff.falls == 3'h0)
            nxt_s.syn_cnt = 20'h00000;
          if (s_ff.falls == 3'(lsd_pkg::SYNCH_FALLS - 1))
          begin
            nxt_s.rx_st                 = lsd_pkg::LSD_RX_ID_WAIT;
            nxt_s.ctrl3[lsd_pkg::C3_SF] = 1'b0;
            if (s_ff.ctrl3[lsd_pkg::C3_ASE])
              nxt_s.lin_divider = lsd_sync_div(s_ff.syn_cnt + 20'h00001);
          end
        end
      end
      lsd_pkg::LSD_RX_ID_WAIT:
      begin
        if (fall)
        begin
          nxt_s.rx_st = lsd_pkg::LSD_RX_ID;
          nxt_s.rx_q  = 8'h00;
        end
      end
      lsd_pkg::LSD_RX_ID:
      begin
        if (qtick)
        begin
          nxt_s.rx_q = s_ff.rx_q + 8'h01;
          if (s_ff.rx_q == 8'(lsd_pkg::ID_CHAR_BITS * lsd_pkg::Q_PER_BIT - 1))
          begin
            // Character received: acts as the receive-full event
            nxt_s.rx_st = lsd_pkg::LSD_RX_IDLE;
            if (s_ff.ctrl3[lsd_pkg::C3_UPD])
            begin
              nxt_s.lin_divider                   = {s_ff.mant, s_ff.frac};
              nxt_s.ctrl3[lsd_pkg::C3_UPD] = 1'b0;
            end
            if (s_ff.ctrl3[lsd_pkg::C3_HDM])
            begin
              nxt_s.ctrl3[lsd_pkg::C3_HDF]  = 1'b1;
              nxt_s.encoded_header_length                     = lsd_enc_len(s_ff.hdr_q);
              nxt_s.ctrl2[lsd_pkg::C2_MUTE] = 1'b0;
            end
          end
        end
      end
      default:
        nxt_s.rx_st = lsd_pkg::LSD_RX_IDLE;
    endcase

    // Header timeout once the maximum header time has passed
    if ((s_ff.rx_st == lsd_pkg::LSD_RX_SYNCH || s_ff.rx_st == lsd_pkg::LSD_RX_ID_WAIT ||
         s_ff.rx_st == lsd_pkg::LSD_RX_ID || s_ff.rx_st == lsd_pkg::LSD_RX_WAIT_HIGH) &&
        s_ff.hdr_q > 8'(lsd_pkg::HDR_MAX_BITS * lsd_pkg::Q_PER_BIT))
    begin
      nxt_s.rx_st                 = lsd_pkg::LSD_RX_IDLE;
      nxt_s.encoded_header_length                   = lsd_pkg::LHL_TIMEOUT;
      nxt_s.ctrl3[lsd_pkg::C3_SF] = 1'b0;
    end

    // Leaving slave mode drops any header in progress
    if (!slave)
      nxt_s.rx_st = lsd_pkg::LSD_RX_IDLE;
  end

  // State register; reset loads constants only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_ff         <= '0;
      s_ff.ctrl2   <= lsd_pkg::RST_REG;
      s_ff.ctrl3   <= lsd_pkg::RST_REG;
      s_ff.encoded_header_length     <= lsd_pkg::RST_REG;
      s_ff.lin_divider    <= lsd_pkg::RST_LIN_DIVIDER;
      s_ff.rx_meta <= 1'b1;
      s_ff.rx_sync <= 1'b1;
      s_ff.rx_prev <= 1'b1;
      s_ff.txd     <= 1'b1;
      s_ff.tx_st   <= lsd_pkg::LSD_TX_IDLE;
      s_ff.rx_st   <= lsd_pkg::LSD_RX_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  // Outputs
  assign prdata = s_ff.prdata;
  assign txd    = s_ff.txd;
  assign irq    = slave & s_ff.ctrl3[lsd_pkg::C3_HIE] & s_ff.ctrl3[lsd_pkg::C3_HDF];

endmodule

// ==== lsd_lin_node.sv ====
// LIN master node model driving the serial receive line
`timescale 1ns/1ps
module lsd_lin_node (
  input  wire logic clk,
  output logic      rxd
);
  // Recessive idle, as a pulled-up LIN bus
  initial rxd = 1'b1;

  // One level held for a number of clocks, changed after an edge
  task automatic hold(input logic v, input int clks);
    rxd <= v;
    repeat (clks) @(posedge clk);
  endtask

  // Optional break plus delimiter, then whole characters LSB first
  task automatic send(input int bc, input int brk, input int nch, input logic [15:0] ch);
    logic [9:0] f;
    if (brk > 0)
    begin
      hold(1'b0, brk * bc);
      hold(1'b1, bc);
    end
    for (int k = 0; k < nch; k++)
    begin
      f = {1'b1, ch[8*k +: 8], 1'b0};
      for (int b = 0; b < 10; b++)
        hold(f[b], bc);
    end
  endtask
endmodule

// ==== lsd_core_asserts.sv ====
// Port level assertions for the LIN header and divider core
`timescale 1ns/1ps
module lsd_core_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rxd,
  input wire logic              txd,
  input wire logic              irq
);
  logic [7:0]  c3_ff;
  logic [7:0]  baud_ff;
  logic        sbk_ff;
  logic        arm_ff;
  logic [15:0] low_ff;
  logic        wr;
  logic        rd;
  logic        acc3;
  logic        slv;
  logic        mst;

  // Decode; control three and baud shadows copy whole written bytes, flag bits of control three included; break shadow copies bit 0
  assign wr   = psel && penable && pwrite;
  assign rd   = psel && penable && !pwrite;
  assign acc3 = psel && penable && paddr == lsd_pkg::OFS_CTRL3;
  assign slv  = c3_ff[6] && c3_ff[5];
  assign mst  = c3_ff[6] && !c3_ff[5];

  // Shadow of mode, baud and break request; length of each low run
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      c3_ff   <= 8'h00;
      baud_ff <= 8'h00;
      sbk_ff  <= 1'b0;
      arm_ff  <= 1'b0;
      low_ff  <= 16'h0000;
    end
    else
    begin
      if (wr && paddr == lsd_pkg::OFS_CTRL3)
        c3_ff <= pwdata[7:0];
      if (wr && paddr == lsd_pkg::OFS_BAUD && !slv)
        baud_ff <= pwdata[7:0];
      if (wr && paddr == lsd_pkg::OFS_CTRL2)
        sbk_ff <= pwdata[0];
      if (wr && paddr == lsd_pkg::OFS_CTRL2 && pwdata[0])
        arm_ff <= 1'b1;
      else if (!txd)
        arm_ff <= 1'b0;
      low_ff <= txd ? 16'h0000 : low_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Settling margin of four cycles after entering slave mode
  AST_SLAVE_TXD_HIGH: assert property (slv && $past(slv, 4) |-> txd)
    else $error("txd went low in slave mode");
  AST_MASTER_BRK_LEN: assert property ($rose(txd) && mst |-> low_ff == 13 * 16 * baud_ff)
    else $error("master break length wrong");
  AST_BRK_STOP_HIGH: assert property ($rose(txd) |-> txd [*8])
    else $error("no high bit after break");
  AST_BRK_REQUESTED: assert property ($fell(txd) |-> arm_ff || sbk_ff)
    else $error("break without request");
  AST_IRQ_GATED: assert property (irq |-> slv && c3_ff[2])
    else $error("irq while disabled");
  AST_IRQ_CLEAR: assert property ($fell(irq) |-> $past(acc3))
    else $error("irq dropped without control three access");
  AST_FRAC_RSV_ZERO: assert property (rd && paddr == lsd_pkg::OFS_ETPR && slv
    |-> prdata[7:4] == 4'h0) else $error("fraction upper bits not zero");
  AST_LEN_HIDDEN: assert property (rd && paddr == lsd_pkg::OFS_ERPR && slv
    && !c3_ff[4] && !c3_ff[3] |-> prdata[7:0] == 8'h00) else $error("length visible");

  CV_MASTER_BRK: cover property ($rose(txd) && mst);
  CV_IRQ: cover property ($rose(irq));
  CV_LEN_READ: cover property (rd && paddr == lsd_pkg::OFS_ERPR && slv);
endmodule

bind lsd_core lsd_core_asserts #(.ADDR_W(ADDR_W)) u_lsd_core_asserts (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));

// ==== lsd_core_tb.sv ====
// Self-checking bench for the LIN header and divider core
`timescale 1ns/1ps
module lsd_core_tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        irq;
  int          n_fail;
  int          compares;
  int          n;
  logic [7:0]  d;
  logic        e;

  lsd_core u_lsd_core (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  lsd_lin_node u_lsd_lin_node (.clk(clk), .rxd(rxd));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; an idle edge after it keeps drives apart
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v,
                      output logic [7:0] q, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    logic       er;
    xfer(1'b1, a, v, q, er);
  endtask

  task automatic ckb(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  // Masked register read compare
  task automatic ck(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] q;
    logic       er;
    xfer(1'b0, a, 8'h00, q, er);
    compares++;
    if ((q & m) !== exp || er !== 1'b0)
    begin
      n_fail++;
      $display("unexpected at %0t: addr %h read %h, wanted %h", $time, a, q, exp);
    end
  endtask

  // Length of the next low run on txd; zero if none starts soon
  task automatic low_len(output int cnt);
    int w;
    cnt = 0;
    w = 0;
    while (txd !== 1'b0 && w < 400)
    begin
      @(posedge clk);
      w++;
    end
    while (txd === 1'b0 && cnt < 1000)
    begin
      @(posedge clk);
      cnt++;
    end
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    n_fail = 0;
    compares = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    ck(lsd_pkg::OFS_CTRL3, 8'hff, 8'h00);
    ck(lsd_pkg::OFS_ETPR, 8'hff, 8'h00);
    xfer(1'b0, 8'h20, 8'h00, d, e);
    ckb(e, 1'b1);
    // Master: set then clear gives exactly one thirteen bit break
    wr(lsd_pkg::OFS_BAUD, 8'h01);
    wr(lsd_pkg::OFS_CTRL3, 8'h40);
    fork
      low_len(n);
      begin
        wr(lsd_pkg::OFS_CTRL2, 8'h01);
        wr(lsd_pkg::OFS_CTRL2, 8'h00);
      end
    join
    ckb(n == 13 * 16, 1'b1);
    low_len(n);
    ckb(n == 0, 1'b1);
    // LIN off: held request keeps sending ten bit breaks
    wr(lsd_pkg::OFS_CTRL3, 8'h00);
    fork
      low_len(n);
      wr(lsd_pkg::OFS_CTRL2, 8'h01);
    join
    ckb(n == 10 * 16, 1'b1);
    low_len(n);
    ckb(n == 10 * 16, 1'b1);
    wr(lsd_pkg::OFS_CTRL2, 8'h00);
    repeat (2) low_len(n);
    // Slave: no break out, zero mantissa stops reception
    wr(lsd_pkg::OFS_CTRL3, 8'h60);
    wr(lsd_pkg::OFS_BAUD, 8'h00);
    fork
      low_len(n);
      wr(lsd_pkg::OFS_CTRL2, 8'h01);
    join
    ckb(n == 0, 1'b1);
    wr(lsd_pkg::OFS_CTRL2, 8'h00);
    u_lsd_lin_node.send(16, 13, 0, 16'h0000);
    ck(lsd_pkg::OFS_STATUS, 8'h03, 8'h00);
    ck(lsd_pkg::OFS_ERPR, 8'hff, 8'h00);
    // Fraction first; only the mantissa write applies it
    wr(lsd_pkg::OFS_ETPR, 8'hfa);
    wr(lsd_pkg::OFS_BAUD, 8'h01);
    ck(lsd_pkg::OFS_BAUD, 8'hff, 8'h01);
    ck(lsd_pkg::OFS_ETPR, 8'hff, 8'h0a);
    wr(lsd_pkg::OFS_ETPR, 8'h00);
    ck(lsd_pkg::OFS_ETPR, 8'hff, 8'h0a);
    wr(lsd_pkg::OFS_BAUD, 8'h01);
    ck(lsd_pkg::OFS_ETPR, 8'hff, 8'h00);
    // Break method: ten low bits too short, thirteen detected
    wr(lsd_pkg::OFS_CTRL3, 8'h74);
    u_lsd_lin_node.send(16, 10, 0, 16'h0000);
    ckb(irq, 1'b0);
    u_lsd_lin_node.send(16, 13, 0, 16'h0000);
    ckb(irq, 1'b1);
    ck(lsd_pkg::OFS_STATUS, 8'h03, 8'h03);
    ck(lsd_pkg::OFS_ERPR, 8'hff, 8'hff);
    wr(lsd_pkg::OFS_CTRL3, 8'h74);
    ck(lsd_pkg::OFS_STATUS, 8'h01, 8'h00);
    ck(lsd_pkg::OFS_CTRL3, 8'h02, 8'h02);
    ckb(irq, 1'b0);
    // Header timeout, then auto synch at half the rate
    u_lsd_lin_node.send(16, 13, 0, 16'h0000);
    repeat (1000) @(posedge clk);
    ck(lsd_pkg::OFS_ERPR, 8'hff, 8'h00);
    u_lsd_lin_node.send(32, 13, 1, 16'h0055);
    ck(lsd_pkg::OFS_BAUD, 8'hff, 8'h02);
    ck(lsd_pkg::OFS_ETPR, 8'hff, 8'h00);
    wr(lsd_pkg::OFS_BAUD, 8'h01);
    ck(lsd_pkg::OFS_BAUD, 8'hff, 8'h01);
    ck(lsd_pkg::OFS_STATUS, 8'h01, 8'h00);
    ck(lsd_pkg::OFS_CTRL3, 8'h02, 8'h02);
    ckb(irq, 1'b0);
    // Let the unfinished header time out before the next one
    repeat (500) @(posedge clk);
    // Identifier method, muted, divider update deferred
    wr(lsd_pkg::OFS_CTRL3, 8'hec);
    wr(lsd_pkg::OFS_CTRL2, 8'h02);
    wr(lsd_pkg::OFS_BAUD, 8'h02);
    ck(lsd_pkg::OFS_BAUD, 8'hff, 8'h01);
    u_lsd_lin_node.send(16, 13, 1, 16'h0055);
    ckb(irq, 1'b0);
    u_lsd_lin_node.send(16, 0, 1, 16'h003c);
    repeat (4) @(posedge clk);
    ckb(irq, 1'b1);
    xfer(1'b0, lsd_pkg::OFS_ERPR, 8'h00, d, e);
    ckb(d >= 8'h5b && d <= 8'h5d, 1'b1);
    ck(lsd_pkg::OFS_BAUD, 8'hff, 8'h02);
    ck(lsd_pkg::OFS_CTRL3, 8'h80, 8'h00);
    ck(lsd_pkg::OFS_CTRL2, 8'h02, 8'h00);
    wrap_up();
  end
endmodule
